// ### rtl/pca_map.svh
// Purpose: bit positions, reset values and fixed figures of the counter array
// Assumes: included by bare name wherever a field position is needed
// Notes: definitions only
`ifndef PCA_MAP_SVH
`define PCA_MAP_SVH

// module mode register bit positions
`define PCA_MODE_PWM16 7
`define PCA_MODE_ECOM 6
`define PCA_MODE_CAPP 5
`define PCA_MODE_CAPN 4
`define PCA_MODE_MAT 3
`define PCA_MODE_TOG 2
`define PCA_MODE_PWM 1
`define PCA_MODE_ECCF 0

// array mode register bit positions
`define PCA_CTL_IDLE 7
`define PCA_CTL_WDEN 6
`define PCA_CTL_WDLOCK 5
`define PCA_CTL_TBSEL_MSB 3
`define PCA_CTL_TBSEL_LSB 1

// reset values
`define PCA_MODE_RST 8'h00
`define PCA_CMP_RST 8'h00
`define PCA_CNT_RST 8'h00
`define PCA_TBSEL_RST 3'h0
`define PCA_WDEN_RST 1'b1

// counter figures
`define PCA_LOW_TOP 8'hff
`define PCA_FULL_TOP 16'hffff
`define PCA_CNT_STEP 16'h0001

`endif

// ### rtl/pca_pkg.sv
// Purpose: shared types of the counter array
// Assumes: used by scoped name only
// Notes: mode codes are one-hot
package pca_pkg;

  // operating mode of one compare module
  typedef enum logic [6:0] {
    MODE_IDLE    = 7'h01,
    MODE_CAPTURE = 7'h02,
    MODE_SWTIMER = 7'h04,
    MODE_HSOUT   = 7'h08,
    MODE_FREQ    = 7'h10,
    MODE_PWM8    = 7'h20,
    MODE_PWM16   = 7'h40
  } mode_e;

endpackage

// ### rtl/pca_mode_decode.sv
// Purpose: turns one module's mode bits into its operating mode
// Assumes: purely combinational, read by the array core
// Notes: forceSw pins the module into software timer mode
`timescale 1ns/1ns
`include "pca_map.svh"

module pca_mode_decode (
  input wire logic [7:0] modeBits,
  input wire logic forceSw,
  output pca_pkg::mode_e unitMode
);

  logic capSel; // any capture edge selected
  logic ecom;
  logic mat;
  logic tog;
  logic pwm;

  assign capSel = modeBits[`PCA_MODE_CAPP] | modeBits[`PCA_MODE_CAPN];
  assign ecom = modeBits[`PCA_MODE_ECOM];
  assign mat = modeBits[`PCA_MODE_MAT];
  assign tog = modeBits[`PCA_MODE_TOG];
  assign pwm = modeBits[`PCA_MODE_PWM];

  // priority decode of the mode table
  always_comb
  begin
    unitMode = pca_pkg::MODE_IDLE;
    if (forceSw)
      unitMode = pca_pkg::MODE_SWTIMER;
    else if (capSel)
      unitMode = (!mat && !tog && !pwm) ? pca_pkg::MODE_CAPTURE : pca_pkg::MODE_IDLE;
    else if (!ecom)
      unitMode = pca_pkg::MODE_IDLE; // constant low output
    else if (pwm && tog)
      unitMode = pca_pkg::MODE_FREQ;
    else if (pwm && modeBits[`PCA_MODE_PWM16])
      unitMode = pca_pkg::MODE_PWM16;
    else if (pwm)
      unitMode = pca_pkg::MODE_PWM8;
    else if (mat && tog)
      unitMode = pca_pkg::MODE_HSOUT;
    else if (mat)
      unitMode = pca_pkg::MODE_SWTIMER;
  end

endmodule // pca_mode_decode

// ### rtl/pca_counter.sv
// Purpose: 16-bit counter of the array with byte writes
// Assumes: advance is a one-cycle pulse per counter clock
// Notes: a byte write beats the increment in the same cycle
`timescale 1ns/1ns
`include "pca_map.svh"

module pca_counter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic advance,
  input wire logic loWr,
  input wire logic hiWr,
  input wire logic [7:0] wrData,
  output logic [7:0] countLo,
  output logic [7:0] countHi
);

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } cnt_s;

  cnt_s q; // current count
  cnt_s next_q; // count for the next edge

  // increment, then let software bytes override
  always_comb
  begin
    next_q = q;
    if (advance)
      next_q = cnt_s'({q.hi, q.lo} + `PCA_CNT_STEP);
    if (loWr)
      next_q.lo = wrData;
    if (hiWr)
      next_q.hi = wrData;
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      q <= {`PCA_CNT_RST, `PCA_CNT_RST};
    else if (clkEn)
      q <= next_q;
  end

  assign countLo = q.lo;
  assign countHi = q.hi;

endmodule // pca_counter

// ### rtl/pca_array.sv
// Purpose: compare, output and watchdog side of a 16-bit counter array
// Assumes: countTick is a one-cycle pulse from the selected timebase
// Notes: software accesses arrive as write strobes with data
`timescale 1ns/1ns
`include "pca_map.svh"

module pca_array #(
  parameter int NMOD = 5,
  parameter int WD_UNIT = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic countTick,
  input wire logic cpuIdle,
  input wire logic [NMOD-1:0] modeWr,
  input wire logic [7:0] modeWrData,
  input wire logic [NMOD-1:0] cmpLoWr,
  input wire logic [NMOD-1:0] cmpHiWr,
  input wire logic [7:0] cmpWrData,
  input wire logic cntLoWr,
  input wire logic cntHiWr,
  input wire logic [7:0] cntWrData,
  input wire logic arrayModeWr,
  input wire logic [7:0] arrayModeData,
  input wire logic counterRunWr,
  input wire logic counterRunData,
  input wire logic flagWr,
  input wire logic [NMOD-1:0] flagWrData,
  output logic [NMOD-1:0] moduleOutputPin,
  output logic [NMOD-1:0] compareFlag,
  output logic [NMOD-1:0] compareIrq,
  output logic [NMOD-1:0][7:0] modeRd,
  output logic [NMOD-1:0][7:0] cmpLoRd,
  output logic [NMOD-1:0][7:0] cmpHiRd,
  output logic [7:0] counterLowByte,
  output logic [7:0] counterHighByte,
  output logic counterRun,
  output logic watchdogEnable,
  output logic watchdogLock,
  output logic idleSuspend,
  output logic [2:0] timebaseSelect,
  output logic watchdogReset
);

  typedef struct packed {
    logic [NMOD-1:0][7:0] mode; // module mode registers
    logic [NMOD-1:0][7:0] cmpLo; // compare low bytes
    logic [NMOD-1:0][7:0] cmpHi; // compare high bytes
    logic [NMOD-1:0] flag; // sticky compare flags
    logic [NMOD-1:0] irq; // flag and its interrupt enable
    logic [NMOD-1:0] cex; // output pin levels
    logic runSoft; // run bit as software wrote it
    logic wdEn; // watchdog active
    logic wdLock; // watchdog locked on
    logic idleSusp; // counter stops while cpu idles
    logic [2:0] tbSel; // timebase select
    logic wdRst; // one-cycle system reset request
  } state_s;

  state_s q; // present state
  state_s next_q; // next state

  logic [7:0] cntLo; // counter low byte
  logic [7:0] cntHi; // counter high byte
  logic [15:0] cntNow; // whole count
  logic [15:0] cntNew; // count after this step
  logic adv; // counter steps this cycle
  logic lowOvf; // low byte rolls 0xff to 0x00
  logic fullOvf; // counter rolls 0xffff to 0x0000
  logic wdMatch; // watchdog high byte equals counter high byte
  logic [NMOD-1:0] hit16; // full compare match on this step
  logic [NMOD-1:0] hit8; // low byte match on this step
  logic [NMOD-1:0] hwFlag; // hardware sets the flag
  pca_pkg::mode_e unitMode [NMOD]; // decoded mode per module

  // counter runs when forced by the watchdog or enabled by software
  assign adv = countTick & (q.runSoft | q.wdEn) & ~(q.idleSusp & cpuIdle);
  assign cntNow = {cntHi, cntLo};
  assign cntNew = cntNow + `PCA_CNT_STEP;
  assign lowOvf = adv & (cntLo == `PCA_LOW_TOP);
  assign fullOvf = adv & (cntNow == `PCA_FULL_TOP);
  assign wdMatch = (q.cmpHi[WD_UNIT] == cntHi);

  // counter bytes are read-only while the watchdog is active
  pca_counter u_counter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .advance(adv),
    .loWr(cntLoWr & ~q.wdEn),
    .hiWr(cntHiWr & ~q.wdEn),
    .wrData(cntWrData),
    .countLo(cntLo),
    .countHi(cntHi)
  );

  // per module: mode decode and match detection on the new count
  genvar g;
  generate
    for (g = 0; g < NMOD; g++)
    begin : g_unit
      pca_mode_decode u_dec (
        .modeBits(q.mode[g]),
        .forceSw((g == WD_UNIT) && q.wdEn),
        .unitMode(unitMode[g])
      );
      // only a step can match, so a held count fires once
      assign hit16[g] = adv & (cntNew == {q.cmpHi[g], q.cmpLo[g]});
      assign hit8[g] = adv & (cntNew[7:0] == q.cmpLo[g]);
    end
  endgenerate

  // next-state logic for control, modules and watchdog
  always_comb
  begin
    next_q = q;
    hwFlag = '0;
    next_q.wdRst = 1'b0;
    // array mode register write
    if (arrayModeWr)
    begin
      // timebase and idle bits frozen while watchdog runs
      if (!q.wdEn)
      begin
        next_q.idleSusp = arrayModeData[`PCA_CTL_IDLE];
        next_q.tbSel = arrayModeData[`PCA_CTL_TBSEL_MSB:`PCA_CTL_TBSEL_LSB];
      end
      // lock only sets; enable follows the lock or the bits
      next_q.wdLock = q.wdLock | arrayModeData[`PCA_CTL_WDLOCK];
      next_q.wdEn = q.wdLock | arrayModeData[`PCA_CTL_WDEN]
        | arrayModeData[`PCA_CTL_WDLOCK];
    end
    // run bit stored as written; watchdog keeps counter going anyway
    if (counterRunWr)
      next_q.runSoft = counterRunData;
    for (int i = 0; i < NMOD; i++)
    begin
      // mode-dependent compare behaviour
      unique case (unitMode[i])
        pca_pkg::MODE_IDLE, pca_pkg::MODE_CAPTURE:
        begin
          next_q.cex[i] = 1'b0;
        end
        pca_pkg::MODE_SWTIMER:
        begin
          hwFlag[i] = hit16[i];
        end
        pca_pkg::MODE_HSOUT:
        begin
          // toggle and flag on every full match
          if (hit16[i])
          begin
            next_q.cex[i] = ~q.cex[i];
            hwFlag[i] = 1'b1;
          end
        end
        pca_pkg::MODE_FREQ:
        begin
          // a zero step wraps the byte, giving 256 clocks
          if (hit8[i])
          begin
            next_q.cex[i] = ~q.cex[i];
            next_q.cmpLo[i] = 8'(q.cmpLo[i] + q.cmpHi[i]);
            hwFlag[i] = q.mode[i][`PCA_MODE_MAT];
          end
        end
        pca_pkg::MODE_PWM8:
        begin
          // overflow reloads; high byte zero keeps the pin high
          if (lowOvf)
          begin
            next_q.cmpLo[i] = q.cmpHi[i];
            next_q.cex[i] = (q.cmpHi[i] == 8'h00);
          end
          else if (hit8[i])
            next_q.cex[i] = 1'b1;
        end
        pca_pkg::MODE_PWM16:
        begin
          // compare zero keeps the pin high through overflow
          if (fullOvf)
            next_q.cex[i] = ({q.cmpHi[i], q.cmpLo[i]} == 16'h0000);
          else if (hit16[i])
            next_q.cex[i] = 1'b1;
          hwFlag[i] = hit16[i] & q.mode[i][`PCA_MODE_MAT];
        end
      endcase
      // mode register, blocked for the watchdog unit while active
      if (modeWr[i] && !((i == WD_UNIT) && q.wdEn))
        next_q.mode[i] = modeWrData;
      // low byte write clears compare enable
      if (cmpLoWr[i])
      begin
        next_q.cmpLo[i] = cmpWrData;
        next_q.mode[i][`PCA_MODE_ECOM] = 1'b0;
      end
      // high byte write sets compare enable; watchdog unit services
      if (cmpHiWr[i])
      begin
        if ((i == WD_UNIT) && q.wdEn)
          next_q.cmpHi[i] = 8'(cntHi + q.cmpLo[i]);
        else
          next_q.cmpHi[i] = cmpWrData;
        next_q.mode[i][`PCA_MODE_ECOM] = 1'b1;
      end
      // flag written by software, hardware set wins
      if (flagWr)
        next_q.flag[i] = flagWrData[i];
      if (hwFlag[i])
        next_q.flag[i] = 1'b1;
      next_q.irq[i] = next_q.flag[i] & next_q.mode[i][`PCA_MODE_ECCF];
    end
    // watchdog expiry on low overflow with high byte match
    if (q.wdEn && lowOvf && wdMatch)
      next_q.wdRst = 1'b1;
    // software forces the reset through the unit flag
    if (q.wdEn && flagWr && flagWrData[WD_UNIT])
      next_q.wdRst = 1'b1;
  end

  // state register, reset enables the watchdog
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      q.mode <= {NMOD{`PCA_MODE_RST}};
      q.cmpLo <= {NMOD{`PCA_CMP_RST}};
      q.cmpHi <= {NMOD{`PCA_CMP_RST}};
      q.flag <= '0;
      q.irq <= '0;
      q.cex <= '0;
      q.runSoft <= 1'b0;
      q.wdEn <= `PCA_WDEN_RST;
      q.wdLock <= 1'b0;
      q.idleSusp <= 1'b0;
      q.tbSel <= `PCA_TBSEL_RST;
      q.wdRst <= 1'b0;
    end
    else if (clkEn)
      q <= next_q;
  end

  // outputs straight from the state register
  assign moduleOutputPin = q.cex;
  assign compareFlag = q.flag;
  assign compareIrq = q.irq;
  assign modeRd = q.mode;
  assign cmpLoRd = q.cmpLo;
  assign cmpHiRd = q.cmpHi;
  assign counterLowByte = cntLo;
  assign counterHighByte = cntHi;
  assign counterRun = q.runSoft;
  assign watchdogEnable = q.wdEn;
  assign watchdogLock = q.wdLock;
  assign idleSuspend = q.idleSusp;
  assign timebaseSelect = q.tbSel;
  assign watchdogReset = q.wdRst;

  // checks on module 0 and the watchdog unit
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // software write sequences on module 0
  sequence s_loWrite;
    clkEn && cmpLoWr[0] && !cmpHiWr[0];
  endsequence
  sequence s_hiWrite;
    clkEn && cmpHiWr[0] && !((WD_UNIT == 0) && q.wdEn);
  endsequence

  property p_flagHold;
    q.flag[0] && !flagWr |=> q.flag[0];
  endproperty
  a_flagHold: assert property (p_flagHold)
    else $error("compare flag cleared without a software write");

  property p_loClears;
    s_loWrite |=> !q.mode[0][`PCA_MODE_ECOM] && q.cmpLo[0] == $past(cmpWrData);
  endproperty
  a_loClears: assert property (p_loClears)
    else $error("low byte write did not clear compare enable");

  property p_hiSets;
    s_hiWrite |=> q.mode[0][`PCA_MODE_ECOM] && q.cmpHi[0] == $past(cmpWrData);
  endproperty
  a_hiSets: assert property (p_hiSets)
    else $error("high byte write did not set compare enable");

  property p_wdAfterReset;
    $past(sys_rst) |-> q.wdEn && !q.wdLock;
  endproperty
  a_wdAfterReset: assert property (p_wdAfterReset)
    else $error("watchdog not enabled after reset");

  property p_lockHolds;
    q.wdLock |-> q.wdEn ##1 q.wdEn && q.wdLock;
  endproperty
  a_lockHolds: assert property (p_lockHolds)
    else $error("locked watchdog was disabled");

  property p_wdExpire;
    clkEn && q.wdEn && lowOvf && wdMatch |=> watchdogReset ##1 (!watchdogReset || !clkEn);
  endproperty
  a_wdExpire: assert property (p_wdExpire)
    else $error("watchdog expiry did not give a one-cycle reset");

  property p_wdForce;
    clkEn && q.wdEn && flagWr && flagWrData[WD_UNIT] |=> watchdogReset;
  endproperty
  a_wdForce: assert property (p_wdForce)
    else $error("flag write did not force watchdog reset");

  property p_cntFrozen;
    clkEn && q.wdEn && cntLoWr && !adv |=> cntLo == $past(cntLo);
  endproperty
  a_cntFrozen: assert property (p_cntFrozen)
    else $error("counter write accepted while watchdog active");

  property p_timerFlag;
    clkEn && unitMode[0] == pca_pkg::MODE_SWTIMER && hit16[0] |=> q.flag[0];
  endproperty
  a_timerFlag: assert property (p_timerFlag)
    else $error("timer match did not set compare flag");

  property p_pwmReload;
    clkEn && unitMode[0] == pca_pkg::MODE_PWM8 && lowOvf && !cmpLoWr[0]
      |=> q.cmpLo[0] == $past(q.cmpHi[0]) && q.cex[0] == ($past(q.cmpHi[0]) == 8'h00);
  endproperty
  a_pwmReload: assert property (p_pwmReload)
    else $error("8-bit pwm overflow did not reload or clear output");

  property p_forcedRun;
    q.wdEn && countTick && clkEn && !(q.idleSusp && cpuIdle) && !cntLoWr
      |=> cntLo == 8'($past(cntLo) + 8'h01);
  endproperty
  a_forcedRun: assert property (p_forcedRun)
    else $error("counter not running while watchdog active");

endmodule // pca_array

// ### verification/pca_pin_load.sv
// Purpose: load on one module output pin, counting its rising edges
// Assumes: the array registers the pin level on mclk
// Notes: the count clears on reset so every case starts from zero
`timescale 1ns/1ns

module pca_pin_load (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pinLevel,
  output logic [1:0] rises
);
  logic lastLevel; // pin level at the previous edge

  // count low to high changes, saturating so a runaway pin stays visible
  always @(posedge mclk)
  begin
    lastLevel <= pinLevel;
    if (sys_rst)
      rises <= 2'h0;
    else if (pinLevel && !lastLevel && rises != 2'h3)
      rises <= rises + 2'h1;
  end
endmodule // pca_pin_load

// ### verification/counter_array_compare_watchdog_tb_top.sv
// Purpose: self-checking bench of the compare side and the watchdog
// Assumes: inputs change by non-blocking assignment at the rising edge
// Notes: table cases run with the watchdog off; watchdog cases follow
`timescale 1ns/1ns

module counter_array_compare_watchdog_tb_top;
  // one table case: settings, stimulus and expected results of unit 0
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] start;
    logic [9:0] n;
    logic pin;
    logic flag;
    logic [7:0] expLo;
    logic [1:0] rise;
  } row_s;

  logic mclk;
  logic sys_rst;
  logic countTick;
  logic [4:0] modeWr, cmpLoWr, cmpHiWr, flagWrData;
  logic [7:0] modeWrData, cmpWrData, cntWrData, arrayModeData;
  logic cntLoWr, cntHiWr, arrayModeWr, counterRunWr, counterRunData, flagWr;
  logic clkEn, cpuIdle; // clock enable and cpu idle level
  logic [4:0] moduleOutputPin, compareFlag, compareIrq;
  logic [4:0][7:0] modeRd, cmpLoRd, cmpHiRd;
  logic [7:0] counterLowByte, counterHighByte;
  logic counterRun, watchdogEnable, watchdogLock, idleSuspend, watchdogReset;
  logic [2:0] timebaseSelect;
  logic [1:0] rises; // rising edges seen by the pin load
  int errCount, samplesChecked, cycles, wdHits;

  // timer, high-speed, frequency, 8-bit and 16-bit pwm cases, and one with compare disabled
  row_s rows [13] = '{
    '{8'h49, 8'h05, 8'h00, 16'h0000, 10'h005, 1'b0, 1'b1, 8'h05, 2'h0},
    '{8'h49, 8'h05, 8'h00, 16'h0000, 10'h004, 1'b0, 1'b0, 8'h05, 2'h0},
    '{8'h4c, 8'h03, 8'h00, 16'h0000, 10'h003, 1'b1, 1'b1, 8'h03, 2'h1},
    '{8'h46, 8'h02, 8'h04, 16'h0000, 10'h002, 1'b1, 1'b0, 8'h06, 2'h1},
    '{8'h46, 8'h02, 8'h04, 16'h0000, 10'h006, 1'b0, 1'b0, 8'h0a, 2'h1},
    '{8'h46, 8'h02, 8'h00, 16'h0000, 10'h102, 1'b0, 1'b0, 8'h02, 2'h1},
    '{8'h42, 8'hf0, 8'h10, 16'h00ef, 10'h001, 1'b1, 1'b0, 8'hf0, 2'h1},
    '{8'h42, 8'hf0, 8'h10, 16'h00ef, 10'h011, 1'b0, 1'b0, 8'h10, 2'h1},
    '{8'h42, 8'h80, 8'h00, 16'h00ff, 10'h001, 1'b1, 1'b0, 8'h00, 2'h1},
    '{8'h42, 8'hff, 8'hff, 16'h00fe, 10'h002, 1'b0, 1'b0, 8'hff, 2'h1},
    '{8'hc2, 8'h34, 8'h12, 16'h1233, 10'h001, 1'b1, 1'b0, 8'h34, 2'h1},
    '{8'hcb, 8'hfe, 8'hff, 16'hfffd, 10'h003, 1'b0, 1'b1, 8'hfe, 2'h1},
    '{8'h82, 8'h34, 8'h12, 16'h1233, 10'h001, 1'b0, 1'b0, 8'h34, 2'h0}
  };

  // device under test
  pca_array i_dut (
    .mclk, .sys_rst, .clkEn, .countTick, .cpuIdle,
    .modeWr, .modeWrData, .cmpLoWr, .cmpHiWr, .cmpWrData,
    .cntLoWr, .cntHiWr, .cntWrData, .arrayModeWr, .arrayModeData,
    .counterRunWr, .counterRunData, .flagWr, .flagWrData,
    .moduleOutputPin, .compareFlag, .compareIrq, .modeRd, .cmpLoRd, .cmpHiRd,
    .counterLowByte, .counterHighByte, .counterRun, .watchdogEnable,
    .watchdogLock, .idleSuspend, .timebaseSelect, .watchdogReset
  );

  // external load on unit 0 pin
  pca_pin_load i_load (.mclk, .sys_rst, .pinLevel(moduleOutputPin[0]), .rises);

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // watchdog pulse count and run limit
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (watchdogReset === 1'b1)
      wdHits = wdHits + 1;
    if (cycles == 20000)
    begin
      errCount = errCount + 1;
      closeOut();
    end
  end

  // compare one observed value with its expectation
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe of kind k to unit u
  task automatic wr(input int k, input int u, input logic [7:0] d);
    @(posedge mclk);
    case (k)
      0: modeWr[u] <= 1'b1;
      1: cmpLoWr[u] <= 1'b1;
      2: cmpHiWr[u] <= 1'b1;
      3: cntLoWr <= 1'b1;
      4: cntHiWr <= 1'b1;
      5: arrayModeWr <= 1'b1;
      6: counterRunWr <= 1'b1;
      default: flagWr <= 1'b1;
    endcase
    modeWrData <= d;
    cmpWrData <= d;
    cntWrData <= d;
    arrayModeData <= d;
    counterRunData <= d[0];
    flagWrData <= d[4:0];
    @(posedge mclk);
    {modeWr, cmpLoWr, cmpHiWr} <= '0;
    {cntLoWr, cntHiWr, arrayModeWr, counterRunWr, flagWr} <= '0;
    #1;
  endtask

  // n back-to-back counter ticks
  task automatic ticks(input int n);
    @(posedge mclk);
    countTick <= 1'b1;
    repeat (n) @(posedge mclk);
    countTick <= 1'b0;
    #1;
  endtask

  // two-cycle reset, optionally leaving the counter under software control
  task automatic resetDut(input logic wdOff);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    wdHits = 0;
    #1;
    if (wdOff)
    begin
      wr(5, 0, 8'h00);
      wr(6, 0, 8'h01);
    end
  endtask

  // counts line, verdict and end of run
  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {sys_rst, countTick, modeWr, cmpLoWr, cmpHiWr, flagWrData} = {2'b10, 20'h0};
    {modeWrData, cmpWrData, cntWrData, arrayModeData} = '0;
    {cntLoWr, cntHiWr, arrayModeWr, counterRunWr, counterRunData, flagWr} = '0;
    {errCount, samplesChecked, cycles, wdHits} = '0;
    {clkEn, cpuIdle} = 2'b10;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      resetDut(1'b1);
      wr(1, 0, rows[i].lo);
      wr(2, 0, rows[i].hi);
      wr(0, 0, rows[i].mode);
      wr(3, 0, rows[i].start[7:0]);
      wr(4, 0, rows[i].start[15:8]);
      ticks(rows[i].n);
      repeat (3) @(posedge mclk);
      #1;
      chk("pin", rows[i].pin, moduleOutputPin[0]);
      chk("flag", rows[i].flag, compareFlag[0]);
      chk("irq", rows[i].flag & rows[i].mode[0], compareIrq[0]);
      chk("cmpLo", rows[i].expLo, cmpLoRd[0]);
      chk("rises", rows[i].rise, rises);
    end
    // watchdog on after reset: restricted writes, counter forced on
    resetDut(1'b0);
    chk("wdOn", 1'b1, watchdogEnable);
    wr(3, 0, 8'h55);
    wr(4, 0, 8'haa);
    wr(5, 0, 8'hce);
    wr(0, 4, 8'h42);
    wr(6, 0, 8'h00);
    ticks(3);
    chk("runBit", 1'b0, counterRun);
    chk("cntLo", 8'h03, counterLowByte);
    chk("cntHi", 8'h00, counterHighByte);
    chk("tbSel", 3'h0, timebaseSelect);
    chk("idle", 1'b0, idleSuspend);
    chk("mode4", 8'h00, modeRd[4]);
    // service with offset one, then run into the timeout
    resetDut(1'b0);
    wr(1, 4, 8'h01);
    wr(2, 4, 8'h77);
    chk("service", 8'h01, cmpHiRd[4]);
    ticks(511);
    @(posedge mclk);
    #1;
    chk("noBite", 0, wdHits);
    chk("cntHiRun", 8'h01, counterHighByte);
    chk("flag4", 1'b1, compareFlag[4]);
    ticks(1);
    @(posedge mclk);
    #1;
    chk("bite", 1, wdHits);
    // forced reset through the unit 4 flag
    resetDut(1'b0);
    wr(7, 0, 8'h10);
    @(posedge mclk);
    #1;
    chk("force", 1, wdHits);
    // lock holds the watchdog on until reset
    resetDut(1'b0);
    wr(5, 0, 8'h20);
    wr(5, 0, 8'h00);
    chk("locked", 1'b1, watchdogEnable);
    chk("lockBit", 1'b1, watchdogLock);
    resetDut(1'b0);
    wr(5, 0, 8'h00);
    chk("unlocked", 1'b0, watchdogEnable);
    chk("noLock", 1'b0, watchdogLock);
    // enable bit follows compare byte writes; flag is sticky
    resetDut(1'b1);
    wr(0, 0, 8'h49);
    wr(1, 0, 8'h02);
    chk("ecomLo", 1'b0, modeRd[0][6]);
    wr(2, 0, 8'h00);
    chk("ecomHi", 1'b1, modeRd[0][6]);
    ticks(7);
    chk("sticky", 1'b1, compareFlag[0]);
    wr(7, 0, 8'h00);
    chk("cleared", 1'b0, compareFlag[0]);
    // settings writable with the watchdog off; idle cpu and low enable hold state
    resetDut(1'b1);
    wr(5, 0, 8'h8e);
    chk("idleSet", 1'b1, idleSuspend);
    chk("tbSet", 3'h7, timebaseSelect);
    @(posedge mclk);
    cpuIdle <= 1'b1;
    ticks(4);
    chk("idleHold", 8'h00, counterLowByte);
    @(posedge mclk);
    cpuIdle <= 1'b0;
    clkEn <= 1'b0;
    ticks(4);
    wr(1, 0, 8'h11);
    chk("enHold", 8'h00, counterLowByte);
    chk("enWrite", 8'h00, cmpLoRd[0]);
    @(posedge mclk);
    clkEn <= 1'b1;
    ticks(2);
    chk("resume", 8'h02, counterLowByte);
    closeOut();
  end
endmodule // counter_array_compare_watchdog_tb_top
